// ===== hw/cta_datapath.v
// Transfer and arithmetic execution datapath with an APB register slave
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`include "cta_defines.vh"

// Overview of operation
// - Zero flag set when result is zero
// - Carry on add carry-out or subtract borrow
// - Auxiliary carry on low nibble carry
// - Overflow when signed result out of range
// - Bit operations only reach addresses 0..0x3F
// - Move memory to accumulator, zero flag only
// - Move port to accumulator, zero flag only
// - Timer word load/store, one cycle, no flags
// - Indirect access takes two cycles, no flags
// - Exchange accumulator with memory, no flags
// - Push flags and accumulator, pointer plus two
// - Pop: pointer minus two, restore all flags
// - Add immediate or memory, all four flags
// - Add with carry of two operands
// - Add carry only to one operand
// - Reverse subtract: negated first plus second
// - Subtract by two's complement of subtrahend
// - Subtract with borrow, single-operand forms too
// - Increment and decrement memory in place
module cta_datapath #(
  parameter MEM_DEPTH = 128,
  parameter MEM_AW = 7
) (
  input wire CLK,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [7:0] PORT_IN,
  output reg [7:0] PORT_OUT,
  output reg BUSY
);

  // ==========================================================
  // States
  localparam ST_IDLE = 2'b00;
  localparam ST_EXEC = 2'b01;
  localparam ST_IDX = 2'b10;

  // ==========================================================
  // Storage
  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [7:0] acc;
  reg [3:0] flag;
  reg [7:0] sp;
  reg [15:0] timer;
  reg timer_run, err;
  reg [1:0] state;
  reg [5:0] op;
  reg [MEM_AW-1:0] op_addr, ptr;
  reg [7:0] op_imm;
  reg [7:0] port_meta, port_sync;

  // ==========================================================
  // Adder/subtractor returning {ov, ac, c, result}
  function [10:0] alu;
    input [7:0] x, y;
    input cin, sub;
    reg [8:0] full;
    reg [4:0] low;
    reg v;
    begin
      if (sub) begin
        full = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        low = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
        v = (x[7] != y[7]) && (full[7] != x[7]);
      end else begin
        full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        v = (x[7] == y[7]) && (full[7] != x[7]);
      end
      alu = {v, low[4], full[8], full[7:0]};
    end
  endfunction

  // ==========================================================
  // Execute decode
  wire [MEM_AW-1:0] addr_up = op_addr + {{(MEM_AW-1){1'b0}}, 1'b1};
  wire [7:0] sp_up = sp + 8'h02;
  wire [7:0] sp_dn = sp - 8'h02;
  wire [MEM_AW-1:0] sp_dn_up = sp_dn[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, 1'b1};
  wire [MEM_AW-1:0] sp_idx_up = sp[MEM_AW-1:0] + {{(MEM_AW-1){1'b0}}, 1'b1};
  wire [7:0] m_op = mem[op_addr];

  reg [7:0] next_acc;
  reg [3:0] next_flag;
  reg [7:0] next_sp;
  reg [15:0] next_timer;
  reg [7:0] next_port;
  reg [MEM_AW-1:0] next_ptr;
  reg next_tload, next_bad, next_idx;
  reg we0, we1;
  reg [MEM_AW-1:0] wa0, wa1;
  reg [7:0] wd0, wd1;
  reg alu_en, alu_mem, acin, asub;
  reg [7:0] ax, ay;
  reg [10:0] ares;

  always @* begin
    // Flags not touched below hold their value
    // Flags default hold
    next_acc = acc;
    next_flag = flag;
    next_sp = sp;
    next_timer = timer;
    next_port = PORT_OUT;
    next_ptr = ptr;
    {next_tload, next_bad, next_idx} = 3'b000;
    {we0, we1, alu_en, alu_mem, acin, asub} = 6'b000000;
    wa0 = op_addr;
    wa1 = addr_up;
    {wd0, wd1} = 16'h0000;
    ax = acc;
    ay = m_op;
    ares = 11'h000;
    if (state == ST_EXEC) begin
      case (op)
        `CTA_OP_MOV_AI: next_acc = op_imm;
        `CTA_OP_MOV_MA: {we0, wd0} = {1'b1, acc};
        `CTA_OP_MOV_AM: begin
          next_acc = m_op;
          next_flag[`CTA_F_Z] = (m_op == 8'h00);
        end
        `CTA_OP_MOV_AIO: begin
          next_acc = port_sync;
          next_flag[`CTA_F_Z] = (port_sync == 8'h00);
        end
        `CTA_OP_MOV_IOA: next_port = acc;
        `CTA_OP_TIMER_LOAD_WORD_OP: begin
          {we0, wd0} = {1'b1, timer[7:0]};
          {we1, wd1} = {1'b1, timer[15:8]};
        end
        `CTA_OP_TIMER_STORE_WORD_OP: begin
          next_tload = 1'b1;
          next_timer = {mem[addr_up], m_op};
        end
        `CTA_OP_IDX_RD, `CTA_OP_IDX_WR: begin
          next_ptr = m_op[MEM_AW-1:0];
          next_idx = 1'b1;
        end
        `CTA_OP_XCH: begin
          next_acc = m_op;
          {we0, wd0} = {1'b1, acc};
        end
        `CTA_OP_PUSH: begin
          {we0, wa0, wd0} = {1'b1, sp[MEM_AW-1:0], acc};
          {we1, wa1, wd1} = {1'b1, sp_idx_up, 4'h0, flag};
          next_sp = sp_up;
        end
        `CTA_OP_POP: begin
          next_sp = sp_dn;
          next_acc = mem[sp_dn[MEM_AW-1:0]];
          next_flag = mem[sp_dn_up][3:0];
        end
        `CTA_OP_ADD_AI: {alu_en, ay} = {1'b1, op_imm};
        `CTA_OP_ADD_AM: alu_en = 1'b1;
        `CTA_OP_ADD_MA: {alu_en, alu_mem} = 2'b11;
        `CTA_OP_ADDC_AM: {alu_en, acin} = {1'b1, flag[`CTA_F_C]};
        `CTA_OP_ADDC_MA: {alu_en, alu_mem, acin} = {2'b11, flag[`CTA_F_C]};
        `CTA_OP_ADDC_A: {alu_en, acin, ay} = {1'b1, flag[`CTA_F_C], 8'h00};
        `CTA_OP_ADDC_M: begin
          {alu_en, alu_mem, acin} = {2'b11, flag[`CTA_F_C]};
          {ax, ay} = {m_op, 8'h00};
        end
        `CTA_OP_NADD_AM: begin
          {alu_en, asub} = 2'b11;
          {ax, ay} = {m_op, acc};
        end
        `CTA_OP_NADD_MA: {alu_en, alu_mem, asub} = 3'b111;
        `CTA_OP_SUB_AI: {alu_en, asub, ay} = {2'b11, op_imm};
        `CTA_OP_SUB_AM: {alu_en, asub} = 2'b11;
        `CTA_OP_SUB_MA: begin
          {alu_en, alu_mem, asub} = 3'b111;
          {ax, ay} = {m_op, acc};
        end
        `CTA_OP_SUBC_AM: {alu_en, asub, acin} = {2'b11, flag[`CTA_F_C]};
        `CTA_OP_SUBC_MA: begin
          {alu_en, alu_mem, asub, acin} = {3'b111, flag[`CTA_F_C]};
          {ax, ay} = {m_op, acc};
        end
        `CTA_OP_SUBC_A: {alu_en, asub, acin, ay} = {2'b11, flag[`CTA_F_C], 8'h00};
        `CTA_OP_SUBC_M: begin
          {alu_en, alu_mem, asub, acin} = {3'b111, flag[`CTA_F_C]};
          {ax, ay} = {m_op, 8'h00};
        end
        `CTA_OP_INC_M, `CTA_OP_DEC_M: begin
          {alu_en, alu_mem} = 2'b11;
          asub = (op == `CTA_OP_DEC_M);
          {ax, ay} = {m_op, 8'h01};
        end
        `CTA_OP_CLEAR_M: we0 = 1'b1;
        `CTA_OP_SET0_M, `CTA_OP_SET1_M: begin
          if (op_addr > `CTA_BIT_ADR_MAX) begin
            next_bad = 1'b1;
          end else begin
            we0 = 1'b1;
            wd0 = (op == `CTA_OP_SET1_M) ? (m_op | (8'h01 << op_imm[2:0]))
                                         : (m_op & ~(8'h01 << op_imm[2:0]));
          end
        end
        default: next_bad = 1'b1;
      endcase
      if (alu_en) begin
        ares = alu(ax, ay, acin, asub);
        next_flag[`CTA_F_Z] = (ares[7:0] == 8'h00);
        next_flag[`CTA_F_C] = ares[8];
        next_flag[`CTA_F_AC] = ares[9];
        next_flag[`CTA_F_OV] = ares[10];
        if (alu_mem) begin
          {we0, wd0} = {1'b1, ares[7:0]};
        end else begin
          next_acc = ares[7:0];
        end
      end
    end else if (state == ST_IDX) begin
      if (op == `CTA_OP_IDX_RD) begin
        next_acc = mem[ptr];
      end else begin
        {we0, wa0, wd0} = {1'b1, ptr, acc};
      end
    end
  end

  // ==========================================================
  // APB decode
  wire setup = PSEL && !PENABLE;
  wire wr_acc = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire in_mem = (PADDR[11:9] == `CTA_MEM_BASE_HI);
  wire [MEM_AW-1:0] bus_idx = PADDR[MEM_AW+1:2];
  reg [31:0] rd_mux;
  reg rd_bad;

  always @* begin
    rd_mux = 32'h00000000;
    rd_bad = 1'b0;
    if (in_mem) begin
      rd_mux = {24'h000000, mem[bus_idx]};
    end else begin
      case (PADDR)
        `CTA_OFF_CMD: rd_mux = {26'h0, op};
        `CTA_OFF_ACC: rd_mux = {24'h000000, acc};
        `CTA_OFF_FLAG: rd_mux = {28'h0000000, flag};
        `CTA_OFF_SP: rd_mux = {24'h000000, sp};
        `CTA_OFF_TIMER: rd_mux = {16'h0000, timer};
        `CTA_OFF_STAT: rd_mux = {30'h0, err, BUSY};
        `CTA_OFF_PORT: rd_mux = {16'h0000, port_sync, PORT_OUT};
        `CTA_OFF_CTRL: rd_mux = {31'h0, timer_run};
        default: rd_bad = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // Port input synchroniser
  always @(posedge CLK) begin
    port_meta <= PORT_IN;
    port_sync <= port_meta;
  end

  // ==========================================================
  // Sequencer, registers and bus answer
  // A command issued while busy is dropped and flagged, so software polls BUSY first
  always @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PORT_OUT <= `CTA_RST_PORT;
      BUSY <= 1'b0;
      acc <= `CTA_RST_ACC;
      flag <= `CTA_RST_FLAG;
      sp <= `CTA_RST_SP;
      timer <= `CTA_RST_TIMER;
      timer_run <= 1'b0;
      err <= 1'b0;
      state <= ST_IDLE;
      op <= 6'h00;
      op_addr <= {MEM_AW{1'b0}};
      op_imm <= 8'h00;
      ptr <= {MEM_AW{1'b0}};
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && rd_bad;
      if (setup) begin
        PRDATA <= rd_mux;
      end
      acc <= next_acc;
      flag <= next_flag;
      sp <= next_sp;
      PORT_OUT <= next_port;
      ptr <= next_ptr;
      if (next_tload) begin
        timer <= next_timer;
      end else if (timer_run) begin
        timer <= timer + 16'h0001;
      end
      case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_EXEC: state <= next_idx ? ST_IDX : ST_IDLE;
        ST_IDX: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
      BUSY <= (state == ST_EXEC) && next_idx;
      // Error set wins over a clear in the same cycle
      if (next_bad) begin
        err <= 1'b1;
      end else if (wr_acc && PADDR == `CTA_OFF_STAT && PWDATA[`CTA_ST_ERR]) begin
        err <= 1'b0;
      end
      if (wr_acc && !in_mem) begin
        case (PADDR)
          `CTA_OFF_CMD: begin
            if (BUSY) begin
              err <= 1'b1;
            end else begin
              op <= PWDATA[`CTA_CMD_OP_HI:`CTA_CMD_OP_LO];
              op_addr <= PWDATA[`CTA_CMD_ADR_HI:`CTA_CMD_ADR_LO];
              op_imm <= PWDATA[`CTA_CMD_IMM_HI:`CTA_CMD_IMM_LO];
              state <= ST_EXEC;
              BUSY <= 1'b1;
            end
          end
          `CTA_OFF_ACC: if (!BUSY) acc <= PWDATA[7:0];
          `CTA_OFF_FLAG: if (!BUSY) flag <= PWDATA[3:0];
          `CTA_OFF_SP: if (!BUSY) sp <= PWDATA[7:0];
          `CTA_OFF_TIMER: if (!BUSY) timer <= PWDATA[15:0];
          `CTA_OFF_PORT: if (!BUSY) PORT_OUT <= PWDATA[7:0];
          `CTA_OFF_CTRL: timer_run <= PWDATA[0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Data memory, execution writes win over bus writes
  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge CLK) begin
        if (RESET) begin
          mem[gi] <= 8'h00;
        end else if (we0 && wa0 == gi) begin
          mem[gi] <= wd0;
        end else if (we1 && wa1 == gi) begin
          mem[gi] <= wd1;
        end else if (wr_acc && in_mem && !BUSY && bus_idx == gi) begin
          mem[gi] <= PWDATA[7:0];
        end
      end
    end
  endgenerate

endmodule

// ===== hw/cta_defines.vh
// Offsets, field positions, opcodes and reset values of the transfer/arith datapath
`ifndef CTA_DEFINES_VH
`define CTA_DEFINES_VH
// ==========================================================
// Register byte offsets
`define CTA_OFF_CMD 12'h000
`define CTA_OFF_ACC 12'h004
`define CTA_OFF_FLAG 12'h008
`define CTA_OFF_SP 12'h00C
`define CTA_OFF_TIMER 12'h010
`define CTA_OFF_STAT 12'h014
`define CTA_OFF_PORT 12'h018
`define CTA_OFF_CTRL 12'h01C
`define CTA_MEM_BASE_HI 3'h1
// ==========================================================
// Command word fields
`define CTA_CMD_OP_HI 5
`define CTA_CMD_OP_LO 0
`define CTA_CMD_ADR_HI 14
`define CTA_CMD_ADR_LO 8
`define CTA_CMD_IMM_HI 23
`define CTA_CMD_IMM_LO 16
// ==========================================================
// Flag bits, status bits, limits
`define CTA_F_Z 0
`define CTA_F_C 1
`define CTA_F_AC 2
`define CTA_F_OV 3
`define CTA_ST_BUSY 0
`define CTA_ST_ERR 1
`define CTA_BIT_ADR_MAX 7'h3F
// ==========================================================
// Reset values
`define CTA_RST_ACC 8'h00
`define CTA_RST_FLAG 4'h0
`define CTA_RST_SP 8'h00
`define CTA_RST_TIMER 16'h0000
`define CTA_RST_PORT 8'h00
// ==========================================================
// Opcodes
`define CTA_OP_MOV_AI 6'h00
`define CTA_OP_MOV_MA 6'h01
`define CTA_OP_MOV_AM 6'h02
`define CTA_OP_MOV_AIO 6'h03
`define CTA_OP_MOV_IOA 6'h04
`define CTA_OP_TIMER_LOAD_WORD_OP 6'h05
`define CTA_OP_TIMER_STORE_WORD_OP 6'h06
`define CTA_OP_IDX_RD 6'h07
`define CTA_OP_IDX_WR 6'h08
`define CTA_OP_XCH 6'h09
`define CTA_OP_PUSH 6'h0A
`define CTA_OP_POP 6'h0B
`define CTA_OP_ADD_AI 6'h0C
`define CTA_OP_ADD_AM 6'h0D
`define CTA_OP_ADD_MA 6'h0E
`define CTA_OP_ADDC_AM 6'h0F
`define CTA_OP_ADDC_MA 6'h10
`define CTA_OP_ADDC_A 6'h11
`define CTA_OP_ADDC_M 6'h12
`define CTA_OP_NADD_AM 6'h13
`define CTA_OP_NADD_MA 6'h14
`define CTA_OP_SUB_AI 6'h15
`define CTA_OP_SUB_AM 6'h16
`define CTA_OP_SUB_MA 6'h17
`define CTA_OP_SUBC_AM 6'h18
`define CTA_OP_SUBC_MA 6'h19
`define CTA_OP_SUBC_A 6'h1A
`define CTA_OP_SUBC_M 6'h1B
`define CTA_OP_INC_M 6'h1C
`define CTA_OP_DEC_M 6'h1D
`define CTA_OP_CLEAR_M 6'h1E
`define CTA_OP_SET0_M 6'h1F
`define CTA_OP_SET1_M 6'h20
`endif

// ===== tb/cta_port_dev.sv
// Port-side device model that drives the input pins of the port register
`timescale 1ns/1ns
module cta_port_dev (
  input wire clk,
  input wire drive,
  input wire [7:0] level,
  output reg [7:0] pins
);
  // ==========================================================
  // Pins
  // Released pins float high through the board pull-ups, never hold the old level
  always @(posedge clk) begin
    pins <= drive ? level : 8'hFF;
  end
endmodule

// ===== tb/cta_datapath_asserts.sv
// Concurrent checks on the bus and command ports of the datapath
`timescale 1ns/1ns
`include "cta_defines.vh"
module cta_datapath_asserts (
  input wire CLK,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [7:0] PORT_IN,
  input wire [7:0] PORT_OUT,
  input wire BUSY
);
  // ==========================================================
  // Decodes
  wire wr_acc = PSEL && PENABLE && PWRITE;
  wire cmd_wr = wr_acc && PADDR == `CTA_OFF_CMD;
  wire [5:0] op = PWDATA[5:0];
  wire is_idx = op == `CTA_OP_IDX_RD || op == `CTA_OP_IDX_WR;
  // Bit ops above the reachable range are refused, so they are left out here
  wire op_ok = op <= `CTA_OP_CLEAR_M || (op <= `CTA_OP_SET1_M && !PWDATA[14]);
  wire map_ok = (PADDR[11:9] == 3'h1 || PADDR[11:5] == 7'h00) && PADDR[1:0] == 2'b00;
  wire map_bad = PADDR[11:10] != 2'b00 || (!PADDR[9] && PADDR[8:5] != 4'h0);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // Sequences
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_take;
    cmd_wr && PREADY && !BUSY;
  endsequence
  sequence s_busy1;
    BUSY ##1 !BUSY;
  endsequence
  sequence s_busy2;
    BUSY [*2] ##1 !BUSY;
  endsequence
  // ==========================================================
  // Properties
  property p_ready;
    s_setup |=> PREADY;
  endproperty
  property p_ready_only;
    !(PSEL && !PENABLE) |=> !PREADY;
  endproperty
  property p_err_bad;
    s_setup ##0 map_bad |=> PSLVERR && PREADY;
  endproperty
  property p_ok_good;
    s_setup ##0 map_ok |=> !PSLVERR;
  endproperty
  property p_idx;
    s_take ##0 is_idx |=> s_busy2;
  endproperty
  property p_single;
    s_take ##0 (op_ok && !is_idx) |=> s_busy1;
  endproperty
  property p_busy_cause;
    $rose(BUSY) |-> $past(cmd_wr);
  endproperty
  property p_busy_max;
    BUSY [*2] |=> !BUSY;
  endproperty
  property p_port_hold;
    $changed(PORT_OUT) |-> $past(BUSY) || $past(wr_acc);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_ready_only: assert property (p_ready_only) else $error("stray ready");
  a_err_bad: assert property (p_err_bad) else $error("unmapped address not refused");
  a_ok_good: assert property (p_ok_good) else $error("mapped address refused");
  a_idx: assert property (p_idx) else $error("indirect op not two cycles");
  a_single: assert property (p_single) else $error("op not one cycle");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  a_port_hold: assert property (p_port_hold) else $error("port output moved idle");
endmodule

// ===== tb/cta_datapath_test.sv
// Self-checking bench for the transfer and arithmetic datapath
`timescale 1ns/1ns
`include "cta_defines.vh"
module cta_datapath_test;
  reg CLK = 1'b0;
  reg RESET = 1'b1;
  reg PSEL = 1'b0;
  reg PENABLE = 1'b0;
  reg PWRITE = 1'b0;
  reg [11:0] PADDR = 12'h000;
  reg [31:0] PWDATA = 32'h00000000;
  reg port_drive = 1'b1;
  reg [7:0] port_level = 8'h00;
  wire [7:0] PORT_IN;
  wire [7:0] PORT_OUT;
  wire [31:0] PRDATA;
  wire PREADY;
  wire PSLVERR;
  wire BUSY;
  integer n_mismatch = 0;
  integer n_tests = 0;
  reg [31:0] rd;
  reg err;
  always #20 CLK = ~CLK;
  cta_datapath u_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT), .BUSY(BUSY));
  cta_port_dev u_port (.clk(CLK), .drive(port_drive), .level(port_level), .pins(PORT_IN));
  // ==========================================================
  // Bus and compare helpers
  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1 && k < 20) begin
        @(posedge CLK);
        k = k + 1;
      end
      if (k == 20) chk(32'h00000000, 32'h00000001, "bus hang");
      rd = PRDATA;
      err = PSLVERR;
      PENABLE <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      bus(1'b1, a, d);
      PSEL <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task chkr(input [11:0] a, input [31:0] exp, input string what);
    begin
      bus(1'b0, a, 32'h00000000);
      PSEL <= 1'b0;
      @(posedge CLK);
      chk(rd, exp, what);
    end
  endtask
  function [11:0] ma(input [6:0] i);
    ma = {`CTA_MEM_BASE_HI, i, 2'b00};
  endfunction
  // Returns {OV, AC, C, Z, result}; C and AC are borrows when subtracting
  function [11:0] alu(input [7:0] x, input [7:0] y, input ci, input sb);
    reg [8:0] s;
    reg [4:0] n;
    reg v;
    begin
      s = sb ? {1'b0, x} - y - ci : x + y + ci;
      n = sb ? {1'b0, x[3:0]} - y[3:0] - ci : x[3:0] + y[3:0] + ci;
      v = sb ? (x[7] != y[7]) && (s[7] != x[7]) : (x[7] == y[7]) && (s[7] != x[7]);
      alu = {v, n[4], s[8], s[7:0] == 8'h00, s[7:0]};
    end
  endfunction
  task cmd(input [5:0] op, input [6:0] adr, input [7:0] imm);
    integer k;
    begin
      k = 0;
      wr(`CTA_OFF_CMD, {8'h00, imm, 1'b0, adr, 2'b00, op});
      @(negedge CLK);
      while (BUSY !== 1'b0 && k < 10) begin
        @(negedge CLK);
        k = k + 1;
      end
      if (k == 10) chk(32'h00000000, 32'h00000001, "busy hang");
      @(posedge CLK);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      chkr(`CTA_OFF_ACC, 32'h00000000, "acc rst");
      chkr(`CTA_OFF_FLAG, 32'h00000000, "flag rst");
      chkr(`CTA_OFF_SP, 32'h00000000, "sp rst");
      chkr(`CTA_OFF_TIMER, 32'h00000000, "timer rst");
      bus(1'b0, 12'h100, 32'h00000000);
      PSEL <= 1'b0;
      @(posedge CLK);
      chk({31'h0, err}, 32'h00000001, "unmapped");
      $display("test reset done");
    end
  endtask
  task t_arith(input [7:0] a, input [7:0] m, input [7:0] i, input c);
    integer op;
    reg [11:0] r;
    reg to_mem;
    begin
      for (op = `CTA_OP_ADD_AI; op <= `CTA_OP_DEC_M; op = op + 1) begin
        case (op[5:0])
          `CTA_OP_ADD_MA, `CTA_OP_ADDC_MA, `CTA_OP_ADDC_M, `CTA_OP_NADD_MA, `CTA_OP_SUB_MA,
          `CTA_OP_SUBC_MA, `CTA_OP_SUBC_M, `CTA_OP_INC_M, `CTA_OP_DEC_M: to_mem = 1'b1;
          default: to_mem = 1'b0;
        endcase
        case (op[5:0])
          `CTA_OP_ADD_AI: r = alu(a, i, 1'b0, 1'b0);
          `CTA_OP_ADD_AM, `CTA_OP_ADD_MA: r = alu(a, m, 1'b0, 1'b0);
          `CTA_OP_ADDC_AM, `CTA_OP_ADDC_MA: r = alu(a, m, c, 1'b0);
          `CTA_OP_ADDC_A: r = alu(a, 8'h00, c, 1'b0);
          `CTA_OP_ADDC_M: r = alu(m, 8'h00, c, 1'b0);
          `CTA_OP_NADD_AM, `CTA_OP_SUB_MA: r = alu(m, a, 1'b0, 1'b1);
          `CTA_OP_NADD_MA, `CTA_OP_SUB_AM: r = alu(a, m, 1'b0, 1'b1);
          `CTA_OP_SUB_AI: r = alu(a, i, 1'b0, 1'b1);
          `CTA_OP_SUBC_AM: r = alu(a, m, c, 1'b1);
          `CTA_OP_SUBC_MA: r = alu(m, a, c, 1'b1);
          `CTA_OP_SUBC_A: r = alu(a, 8'h00, c, 1'b1);
          `CTA_OP_SUBC_M: r = alu(m, 8'h00, c, 1'b1);
          `CTA_OP_INC_M: r = alu(m, 8'h01, 1'b0, 1'b0);
          default: r = alu(m, 8'h01, 1'b0, 1'b1);
        endcase
        wr(`CTA_OFF_ACC, {24'h000000, a});
        // Stale flags set on purpose so that a flag left alone shows up
        wr(`CTA_OFF_FLAG, {28'h0000000, 2'b11, c, 1'b1});
        wr(ma(7'h05), {24'h000000, m});
        cmd(op[5:0], 7'h05, i);
        chkr(`CTA_OFF_ACC, {24'h000000, to_mem ? a : r[7:0]}, "acc");
        chkr(ma(7'h05), {24'h000000, to_mem ? r[7:0] : m}, "mem");
        chkr(`CTA_OFF_FLAG, {28'h0000000, r[11:8]}, "flags");
      end
      $display("test arith done");
    end
  endtask
  task t_move;
    begin
      wr(`CTA_OFF_FLAG, 32'h0000000E);
      wr(ma(7'h10), 32'h0000005A);
      cmd(`CTA_OP_MOV_AM, 7'h10, 8'h00);
      chkr(`CTA_OFF_FLAG, 32'h0000000E, "mov nz");
      chkr(`CTA_OFF_ACC, 32'h0000005A, "mov acc");
      cmd(`CTA_OP_MOV_AIO, 7'h00, 8'h00);
      chkr(`CTA_OFF_ACC, 32'h00000000, "port acc");
      chkr(`CTA_OFF_FLAG, 32'h0000000F, "port z");
      wr(`CTA_OFF_ACC, 32'h000000C3);
      cmd(`CTA_OP_MOV_IOA, 7'h00, 8'h00);
      chkr(`CTA_OFF_PORT, 32'h000000C3, "port out");
      cmd(`CTA_OP_XCH, 7'h10, 8'h00);
      chkr(`CTA_OFF_ACC, 32'h0000005A, "xch acc");
      chkr(ma(7'h10), 32'h000000C3, "xch mem");
      chkr(`CTA_OFF_FLAG, 32'h0000000F, "xch flag");
      cmd(`CTA_OP_MOV_AI, 7'h00, 8'h96);
      cmd(`CTA_OP_MOV_MA, 7'h11, 8'h00);
      chkr(ma(7'h11), 32'h00000096, "mov imm mem");
      chkr(`CTA_OFF_FLAG, 32'h0000000F, "mov imm flag");
      port_drive <= 1'b0;
      repeat (4) @(posedge CLK);
      cmd(`CTA_OP_MOV_AIO, 7'h00, 8'h00);
      chkr(`CTA_OFF_FLAG, 32'h0000000E, "port nz");
      $display("test move done");
    end
  endtask
  task t_stack;
    begin
      wr(`CTA_OFF_SP, 32'h00000020);
      wr(`CTA_OFF_ACC, 32'h0000005A);
      wr(`CTA_OFF_FLAG, 32'h00000009);
      cmd(`CTA_OP_PUSH, 7'h00, 8'h00);
      chkr(`CTA_OFF_SP, 32'h00000022, "push sp");
      chkr(ma(7'h20), 32'h0000005A, "push acc");
      chkr(ma(7'h21), 32'h00000009, "push flag");
      wr(`CTA_OFF_ACC, 32'h00000000);
      wr(`CTA_OFF_FLAG, 32'h00000006);
      cmd(`CTA_OP_POP, 7'h00, 8'h00);
      chkr(`CTA_OFF_SP, 32'h00000020, "pop sp");
      chkr(`CTA_OFF_ACC, 32'h0000005A, "pop acc");
      chkr(`CTA_OFF_FLAG, 32'h00000009, "pop flag");
      $display("test stack done");
    end
  endtask
  task t_word;
    begin
      wr(ma(7'h30), 32'h00000034);
      wr(ma(7'h31), 32'h00000012);
      wr(`CTA_OFF_FLAG, 32'h00000005);
      cmd(`CTA_OP_TIMER_STORE_WORD_OP, 7'h30, 8'h00);
      chkr(`CTA_OFF_TIMER, 32'h00001234, "stt");
      cmd(`CTA_OP_TIMER_LOAD_WORD_OP, 7'h40, 8'h00);
      chkr(ma(7'h41), 32'h00000012, "ldt hi");
      // Timer runs for three edges between the two control writes
      wr(`CTA_OFF_CTRL, 32'h00000001);
      wr(`CTA_OFF_CTRL, 32'h00000000);
      chkr(`CTA_OFF_TIMER, 32'h00001237, "timer run");
      wr(ma(7'h48), 32'h00000050);
      wr(ma(7'h50), 32'h000000A5);
      cmd(`CTA_OP_IDX_RD, 7'h48, 8'h00);
      chkr(`CTA_OFF_ACC, 32'h000000A5, "idx rd");
      wr(`CTA_OFF_ACC, 32'h0000003C);
      cmd(`CTA_OP_IDX_WR, 7'h48, 8'h00);
      chkr(ma(7'h50), 32'h0000003C, "idx wr");
      chkr(`CTA_OFF_FLAG, 32'h00000005, "idx flag");
      // Second command lands while the indirect op is still busy
      bus(1'b1, `CTA_OFF_CMD, {24'h000048, 2'b00, `CTA_OP_IDX_RD});
      bus(1'b1, `CTA_OFF_CMD, {24'h000050, 2'b00, `CTA_OP_INC_M});
      PSEL <= 1'b0;
      repeat (3) @(posedge CLK);
      chkr(ma(7'h50), 32'h0000003C, "busy cmd");
      chkr(`CTA_OFF_STAT, 32'h00000002, "busy err");
      wr(`CTA_OFF_STAT, 32'h00000002);
      wr(ma(7'h3F), 32'h00000010);
      cmd(`CTA_OP_SET1_M, 7'h3F, 8'h02);
      chkr(ma(7'h3F), 32'h00000014, "bit 3f");
      cmd(`CTA_OP_SET1_M, 7'h40, 8'h02);
      chkr(ma(7'h40), 32'h00000034, "bit 40");
      chkr(`CTA_OFF_STAT, 32'h00000002, "bit err");
      cmd(`CTA_OP_SET0_M, 7'h3F, 8'h04);
      chkr(ma(7'h3F), 32'h00000004, "bit clr");
      cmd(`CTA_OP_CLEAR_M, 7'h3F, 8'h00);
      chkr(ma(7'h3F), 32'h00000000, "clear");
      wr(`CTA_OFF_STAT, 32'h00000002);
      chkr(`CTA_OFF_STAT, 32'h00000000, "err clr");
      cmd(6'h21, 7'h00, 8'h00);
      chkr(`CTA_OFF_STAT, 32'h00000002, "bad op");
      $display("test word done");
    end
  endtask
  // ==========================================================
  // Run control
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_reset;
    t_arith(8'h7F, 8'h01, 8'h0F, 1'b1);
    t_arith(8'h80, 8'h80, 8'h80, 1'b0);
    t_arith(8'h0F, 8'h3C, 8'h01, 1'b1);
    t_move;
    t_stack;
    t_word;
    summarize;
  end
  // Whole run needs under two thousand cycles; this span leaves ample slack
  initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
endmodule
bind cta_datapath cta_datapath_asserts u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT), .BUSY(BUSY));
